// [rtl/fbgp_pin_cell.sv]
// One pin of the port: drive select, standby isolation, pull-up and input path.
// Assumes all controls are synchronous to core_clk; pad level comes back on pad_in.
`timescale 1ns/1ns

module fbgp_pin_cell
    import fbgp_pkg::*;
(
    input wire logic latch_bit,
    input wire logic dir_bit,
    input wire logic pullup_bit,
    input wire logic periph_oe,
    input wire logic periph_out,
    input wire logic force_hiz,
    input wire logic keep_input,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pullup_on,
    output logic pin_value
);
    wire logic drive_req;
    wire logic drive_val;

    // Peripheral takeover wins over the port direction.
    assign drive_req = periph_oe | dir_bit;
    assign drive_val = periph_oe ? periph_out : latch_bit;
    assign pad_oe = drive_req & ~force_hiz;
    assign pad_out = drive_val;
    // A driven low pad would only waste current through the pull-up.
    assign pullup_on = pullup_bit & ~(pad_oe & ~drive_val);
    // Blocked inputs read low so a floating pad cannot leak.
    assign pin_value = pad_in & (~force_hiz | keep_input);
endmodule

// [rtl/fbgp_port.sv]
// Top of the five-pin general-purpose port: bus slave, standby control, pin cells.
// Assumes a bus master with one-cycle strobes and pads resolved outside from pad_oe.
`timescale 1ns/1ns
`include "fbgp_cfg.svh"

module fbgp_port
    import fbgp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [`FBGP_ADDR_W-1:0] bus_addr,
    input wire fbgp_byte_t bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_rd_rmw,
    output fbgp_byte_t bus_rdata,
    input wire fbgp_pins_t periph_oe,
    input wire fbgp_pins_t periph_out,
    output fbgp_pins_t periph_in,
    input wire logic stop_or_watch,
    input wire logic ext_int_ch0_enable,
    input wire logic wakeup_pin_select,
    input wire fbgp_pins_t pad_in,
    output fbgp_pins_t pad_out,
    output fbgp_pins_t pad_oe,
    output fbgp_pins_t pullup_on
);
    fbgp_pins_t port_output_latch;
    fbgp_pins_t port_direction;
    fbgp_pins_t port_pullup_enable;
    fbgp_pins_t pin_value;
    fbgp_pins_t latch_view;
    fbgp_pins_t pin_or_latch;
    fbgp_byte_t next_rdata;
    fbgp_mode_e mode;
    logic standby_pin_state_bit;
    wire logic sel_latch;
    wire logic sel_dir;
    wire logic sel_pullup;
    wire logic sel_standby;
    wire logic force_hiz;
    wire logic keep_clk_input;

    assign sel_latch = bus_addr == `FBGP_OFF_LATCH;
    assign sel_dir = bus_addr == `FBGP_OFF_DIR;
    assign sel_pullup = bus_addr == `FBGP_OFF_PULLUP;
    assign sel_standby = bus_addr == `FBGP_OFF_STANDBY;

    fbgp_regfile u_regs (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_latch(bus_wr & sel_latch),
        .wr_dir(bus_wr & sel_dir),
        .wr_pullup(bus_wr & sel_pullup),
        .wr_standby(bus_wr & sel_standby),
        .wdata(bus_wdata),
        .port_output_latch(port_output_latch),
        .port_direction(port_direction),
        .port_pullup_enable(port_pullup_enable),
        .standby_pin_state_bit(standby_pin_state_bit)
    );

    // Standby mode decode; only the isolating mode changes the pins.
    always_comb begin
        case ({stop_or_watch, standby_pin_state_bit})
            2'b10: mode = FBGP_STBY_HOLD;
            2'b11: mode = FBGP_STBY_HIZ;
            default: mode = FBGP_RUN;
        endcase
    end

    assign force_hiz = mode == FBGP_STBY_HIZ;
    // The counter clock pin keeps its input so it can still wake the part.
    assign keep_clk_input = ext_int_ch0_enable & wakeup_pin_select;

    genvar i;
    generate
        for (i = 0; i < `FBGP_PINS; i++) begin : g_pin
            fbgp_pin_cell u_cell (
                .latch_bit(port_output_latch[i]),
                .dir_bit(port_direction[i]),
                .pullup_bit(port_pullup_enable[i]),
                .periph_oe(periph_oe[i]),
                .periph_out(periph_out[i]),
                .force_hiz(force_hiz),
                .keep_input((i == `FBGP_CLK_PIN) ? keep_clk_input : 1'b0),
                .pad_in(pad_in[i]),
                .pad_out(pad_out[i]),
                .pad_oe(pad_oe[i]),
                .pullup_on(pullup_on[i]),
                .pin_value(pin_value[i])
            );
            // Output-port pins read the latch; others read the pad level.
            assign pin_or_latch[i] = (port_direction[i] & ~periph_oe[i]) ? port_output_latch[i] : pin_value[i];
        end
    endgenerate

    assign periph_in = pin_value;
    assign latch_view = bus_rd_rmw ? port_output_latch : pin_or_latch;

    always_comb begin
        next_rdata = 8'h00;
        if (sel_latch) next_rdata = {3'h0, latch_view};
        else if (sel_dir) next_rdata = {3'h0, port_direction};
        else if (sel_pullup) next_rdata = {3'h0, port_pullup_enable};
        else if (sel_standby) next_rdata = {7'h00, standby_pin_state_bit};
    end

    // Read data stands only in the cycle after the strobe; otherwise zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst) bus_rdata <= 8'h00;
        else if (bus_rd) bus_rdata <= next_rdata;
        else bus_rdata <= 8'h00;
    end

    a_out_drives_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (port_direction[0] && !periph_oe[0] && !force_hiz) |-> (pad_oe[0] && pad_out[0] == port_output_latch[0]))
        else $error("output pin not driving latch");
    a_in_not_driven: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!port_direction[1] && !periph_oe[1]) |-> !pad_oe[1]) else $error("input pin driven");
    a_periph_takes_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
        (periph_oe[2] && !force_hiz) |-> (pad_oe[2] && pad_out[2] == periph_out[2]))
        else $error("peripheral output not on pin");
    a_hiz_standby: assert property (@(posedge core_clk) disable iff (sys_rst)
        force_hiz |-> (pad_oe == 5'h00 && pin_value[3:0] == 4'h0)) else $error("standby pins not isolated");
    a_clk_pin_open: assert property (@(posedge core_clk) disable iff (sys_rst)
        (force_hiz && keep_clk_input) |-> pin_value[4] == pad_in[4]) else $error("wake pin blocked");
    a_hold_standby: assert property (@(posedge core_clk) disable iff (sys_rst)
        (stop_or_watch && !standby_pin_state_bit) |-> pad_oe == (port_direction | periph_oe))
        else $error("pin state changed in hold standby");
    a_pullup_low_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pad_oe[0] && !pad_out[0]) |-> !pullup_on[0]) else $error("pull-up on driven low pin");
    a_pullup_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
        !pad_oe[3] |-> pullup_on[3] == port_pullup_enable[3]) else $error("pull-up not following enable");
    a_read_rmw_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_rd && bus_rd_rmw && sel_latch) |=> bus_rdata == {3'h0, $past(port_output_latch)})
        else $error("rmw read not latch");
    a_read_input_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_rd && !bus_rd_rmw && sel_latch && !port_direction[0] && !force_hiz) |=> bus_rdata[0] == $past(pad_in[0]))
        else $error("input read not pin");
    a_upper_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus_rdata[7:5] == 3'h0) else $error("upper bits not zero");
    // Outside isolating standby every pin is driven exactly when the port or a peripheral claims it.
    a_dir_sets_oe: assert property (@(posedge core_clk) disable iff (sys_rst)
        !force_hiz |-> pad_oe == (port_direction | periph_oe)) else $error("direction not applied to pins");
    a_out_read_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_rd && !bus_rd_rmw && sel_latch && port_direction[1] && !periph_oe[1])
        |=> bus_rdata[1] == $past(port_output_latch[1])) else $error("output pin read not latch");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_rd && bus_addr > `FBGP_OFF_STANDBY) |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
    // Read data must not linger, or a later idle cycle could be taken as a fresh answer.
    a_rdata_one_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
        !bus_rd |=> bus_rdata == 8'h00) else $error("read data held too long");
endmodule

// [rtl/fbgp_regfile.sv]
// Storage for the latch, direction, pull-up and standby pin-state registers.
// Assumes one-cycle write strobes from the bus decoder in the top module.
`timescale 1ns/1ns
`include "fbgp_cfg.svh"

module fbgp_regfile
    import fbgp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_latch,
    input wire logic wr_dir,
    input wire logic wr_pullup,
    input wire logic wr_standby,
    input wire fbgp_byte_t wdata,
    output fbgp_pins_t port_output_latch,
    output fbgp_pins_t port_direction,
    output fbgp_pins_t port_pullup_enable,
    output logic standby_pin_state_bit
);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_output_latch <= `FBGP_LATCH_RST;
            port_direction <= `FBGP_DIR_RST;
            port_pullup_enable <= `FBGP_PULLUP_RST;
            standby_pin_state_bit <= 1'b0;
        end else begin
            // The latch takes every write whatever the direction.
            if (wr_latch) port_output_latch <= wdata[`FBGP_MSB:0];
            if (wr_dir) port_direction <= wdata[`FBGP_MSB:0];
            if (wr_pullup) port_pullup_enable <= wdata[`FBGP_MSB:0];
            if (wr_standby) standby_pin_state_bit <= wdata[`FBGP_STBY_SPL_BIT];
        end
    end

    a_reset_dir_clear: assert property (@(posedge core_clk)
        sys_rst |=> port_direction == 5'h00) else $error("direction not cleared by reset");
    a_latch_write_any: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_latch |=> port_output_latch == $past(wdata[`FBGP_MSB:0])) else $error("latch write lost");
endmodule

// [shared/fbgp_cfg.svh]
// Offsets, field positions, reset values and sizes for the five-pin port.
// Assumes inclusion by bare name from the package or design files.
`ifndef FBGP_CFG_SVH
`define FBGP_CFG_SVH

`define FBGP_ADDR_W 4
`define FBGP_OFF_LATCH 4'h0
`define FBGP_OFF_DIR 4'h1
`define FBGP_OFF_PULLUP 4'h2
`define FBGP_OFF_STANDBY 4'h3
`define FBGP_PINS 5
`define FBGP_MSB 4
`define FBGP_LATCH_RST 5'h00
`define FBGP_DIR_RST 5'h00
`define FBGP_PULLUP_RST 5'h00
`define FBGP_STBY_SPL_BIT 0
`define FBGP_STBY_RST 8'h00
`define FBGP_CLK_PIN 4

`endif

// [shared/fbgp_pkg.sv]
// Types shared by the port files.
// Assumes the configuration header is on the include path.
`include "fbgp_cfg.svh"

package fbgp_pkg;
    typedef logic [`FBGP_MSB:0] fbgp_pins_t;
    typedef logic [7:0] fbgp_byte_t;
    typedef enum logic [1:0] {
        FBGP_RUN,
        FBGP_STBY_HOLD,
        FBGP_STBY_HIZ
    } fbgp_mode_e;
endpackage

// [tb/fbgp_pad_model.sv]
// Pad and board model for the five port pins.
// Assumes pad_out, pad_oe and pullup_on come straight from the port.
`timescale 1ns/1ns

module fbgp_pad_model
    import fbgp_pkg::*;
(
    input wire logic core_clk,
    input wire fbgp_pins_t pad_out,
    input wire fbgp_pins_t pad_oe,
    input wire fbgp_pins_t pullup_on,
    input wire fbgp_pins_t ext_en,
    input wire fbgp_pins_t ext_val,
    output fbgp_pins_t pad_in
);
    fbgp_pins_t float_pat = 5'h0A;

    // A floating pin toggles so that a stale value never looks like a match.
    always @(posedge core_clk) float_pat <= ~float_pat;

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pullup_on[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = float_pat[i];
            end
        end
    end
endmodule

// [tb/fbgp_port_bench.sv]
// Self-checking bench for the five-pin port, driving the register bus and pins.
// Assumes the pad model resolves the pins and the port answers reads one cycle late.
`timescale 1ns/1ns

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module fbgp_port_bench
    import fbgp_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    fbgp_byte_t bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic bus_rd_rmw = 1'b0;
    fbgp_byte_t bus_rdata;
    fbgp_pins_t periph_oe = 5'h00;
    fbgp_pins_t periph_out = 5'h00;
    fbgp_pins_t periph_in, pad_in, pad_out, pad_oe, pullup_on;
    logic stop_or_watch = 1'b0;
    logic ext_int_ch0_enable = 1'b0;
    logic wakeup_pin_select = 1'b0;
    fbgp_pins_t ext_en = 5'h10;
    fbgp_pins_t ext_val = 5'h00;
    int bad_count = 0;
    int checks_done = 0;

    fbgp_port u_fbgp_port (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rd_rmw(bus_rd_rmw),
        .bus_rdata(bus_rdata), .periph_oe(periph_oe), .periph_out(periph_out),
        .periph_in(periph_in), .stop_or_watch(stop_or_watch),
        .ext_int_ch0_enable(ext_int_ch0_enable), .wakeup_pin_select(wakeup_pin_select),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pullup_on));

    fbgp_pad_model u_fbgp_pad_model (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic wr(input logic [3:0] a, input fbgp_byte_t d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic read_modify_write_instruction, input fbgp_byte_t exp);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        bus_rd_rmw <= read_modify_write_instruction;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        bus_rd_rmw <= 1'b0;
        @(negedge core_clk);
        `CHK(bus_rdata, exp)
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(4'h1, 1'b0, 8'h00);
        rd(4'h0, 1'b1, 8'h00);
        rd(4'h2, 1'b0, 8'h00);
        `CHK(pad_oe, 5'h00)
        $display("test reset done");
        wr(4'h1, 8'hEF);
        rd(4'h1, 1'b0, 8'h0F);
        wr(4'h0, 8'hF5);
        `CHK(pad_oe, 5'h0F)
        `CHK(pad_out[3:0], 4'h5)
        rd(4'h0, 1'b0, 8'h05);
        rd(4'h0, 1'b1, 8'h15);
        rd(4'h5, 1'b0, 8'h00);
        wr(4'h1, 8'h1F);
        `CHK(pad_out, 5'h15)
        wr(4'h1, 8'h0F);
        $display("test direction done");
        @(posedge core_clk);
        periph_oe <= 5'h01;
        @(negedge core_clk);
        `CHK(pad_out[0], 1'b0)
        `CHK(pad_oe[0], 1'b1)
        rd(4'h0, 1'b0, 8'h04);
        rd(4'h0, 1'b1, 8'h15);
        @(posedge core_clk);
        periph_oe <= 5'h00;
        ext_val <= 5'h10;
        rd(4'h0, 1'b0, 8'h15);
        $display("test peripheral done");
        ext_en <= 5'h00;
        wr(4'h2, 8'hFF);
        `CHK(pullup_on, 5'h15)
        rd(4'h2, 1'b0, 8'h1F);
        rd(4'h0, 1'b0, 8'h15);
        $display("test pullup done");
        wr(4'h3, 8'h01);
        ext_en <= 5'h1F;
        ext_val <= 5'h1F;
        stop_or_watch <= 1'b1;
        @(negedge core_clk);
        `CHK(pad_oe, 5'h00)
        `CHK(periph_in, 5'h00)
        @(posedge core_clk);
        ext_int_ch0_enable <= 1'b1;
        wakeup_pin_select <= 1'b1;
        @(negedge core_clk);
        `CHK(periph_in, 5'h10)
        wr(4'h3, 8'h00);
        `CHK(pad_oe, 5'h0F)
        `CHK(pad_out[3:0], 4'h5)
        $display("test standby done");
        stop_test();
    end
endmodule
